//--- logic/mrsc_flags.sv
// Sticky reset-cause flag register where a set beats a clear.
`timescale 1ns/1ps
module mrsc_flags (
    input  wire logic  clock,       // System clock.
    input  wire logic  reset,       // Asynchronous reset, active high.
    mrsc_flag_if.owner fl           // Set, clear and value vectors.
);
    import mrsc_pkg::*;

    typedef struct packed {
        logic [4:0] flags;
    } mrsc_flag_state_t;

    mrsc_flag_state_t state;
    mrsc_flag_state_t next_state;

    // ==================================================================
    // An event in the cycle of its clear is kept, so no cause is lost.
    always_comb begin
        next_state       = state;
        next_state.flags = (state.flags & ~fl.clr) | fl.set;
    end

    // Flags come out of reset cleared.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state.flags <= MRSC_FLAG_RST;
        end else begin
            state <= next_state;
        end
    end

    assign fl.flags = state.flags;
endmodule

//--- logic/mrsc_top.sv
// Peripheral reset control and system status registers of the host side.
`timescale 1ns/1ps
module mrsc_top (
    input  wire logic                  clock,            // 10 MHz clock.
    input  wire logic                  reset,            // Async, high.
    input  wire logic                  bus_sel,          // Access strobe.
    input  wire logic                  bus_write,        // 1 write, 0 read.
    input  wire logic [0:0]            bus_addr,         // Register index.
    input  wire logic [mrsc_pkg::MRSC_DATA_W-1:0] bus_wdata, // Write data.
    output logic [mrsc_pkg::MRSC_DATA_W-1:0]      bus_rdata, // Read data.
    output logic                       bus_ack,          // Answer pulse.
    input  wire logic                  chip_reset_in_n,  // Chip reset pin.
    input  wire logic                  dsp_idle,         // DSP global idle.
    input  wire logic                  power_on_detect,  // Cold start seen.
    input  wire logic                  core_reset_detect, // Core was reset.
    input  wire logic                  watchdog_detect,  // Watchdog reset.
    input  wire logic                  soft_reset_request, // Global soft.
    output logic                       host_periph_reset_n, // Periph reset.
    output logic [2:0]                 clock_scheme      // Active scheme.
);
    import mrsc_pkg::*;

    // ==================================================================
    // State of the block apart from the cause flags, all in one packed record.
    typedef struct packed {
        logic                   periph_release;
        logic [2:0]             scheme;
        logic [MRSC_IN_W-1:0]   meta;
        logic [MRSC_IN_W-1:0]   sync;
        logic [MRSC_IN_W-1:0]   prev;
        logic [MRSC_DATA_W-1:0] rdata;
        logic                   ack;
    } mrsc_state_t;

    mrsc_state_t          state;
    mrsc_state_t          next_state;
    logic [MRSC_IN_W-1:0] raw_in;
    logic [MRSC_IN_W-1:0] rise;
    logic                 chip_pulse;
    logic                 wr_ctl;
    logic                 wr_st;
    logic [2:0]           wr_scheme;
    logic [4:0]           sw_clear;
    logic [MRSC_DATA_W-1:0] ctl_view;
    logic [MRSC_DATA_W-1:0] st_view;

    mrsc_flag_if flag_bus ();

    // ==================================================================
    // Input gathering.
    // The chip reset pin is inverted ahead of the synchroniser so every
    // event input is active high and one edge detector serves all.
    always_comb begin
        raw_in               = MRSC_IN_RST;
        raw_in[MRSC_IN_CHIP] = ~chip_reset_in_n;
        raw_in[MRSC_IN_IDLE] = dsp_idle;
        raw_in[MRSC_IN_POR]  = power_on_detect;
        raw_in[MRSC_IN_CORE] = core_reset_detect;
        raw_in[MRSC_IN_WD]   = watchdog_detect;
        raw_in[MRSC_IN_SOFT] = soft_reset_request;
    end

    // Edges are taken from the second stage only; the first stage may
    // still be settling and must feed nothing but the second.
    assign rise       = mrsc_rise(state.sync, state.prev);
    assign chip_pulse = rise[MRSC_IN_CHIP];

    // ==================================================================
    // Register port decode.
    always_comb begin
        wr_ctl = 1'b0;
        wr_st  = 1'b0;
        if (bus_sel && bus_write && bus_addr == MRSC_IDX_CONTROL) begin
            wr_ctl = 1'b1;
        end else if (bus_sel && bus_write &&
                     bus_addr == MRSC_IDX_STATUS) begin
            wr_st = 1'b1;
        end
    end

    assign wr_scheme = bus_wdata[MRSC_ST_SCHEME_MSB:MRSC_ST_SCHEME_LSB];

    // Only a 0 in a flag position clears it; a 1 is a no-op, so one
    // flag can be cleared without a read-modify-write race.
    assign sw_clear = wr_st ?
        ~bus_wdata[MRSC_ST_FLAG_MSB:MRSC_ST_FLAG_LSB] : 5'h00;

    // ==================================================================
    // Flag set and clear sources.
    always_comb begin
        flag_bus.set               = MRSC_FLAG_RST;
        flag_bus.set[MRSC_FL_POR]  = rise[MRSC_IN_POR];
        flag_bus.set[MRSC_FL_EXT]  = chip_pulse;
        flag_bus.set[MRSC_FL_CORE] = rise[MRSC_IN_CORE];
        flag_bus.set[MRSC_FL_WD]   = rise[MRSC_IN_WD];
        // The soft reset request is raised by the reset sequencer once
        // software writes the two controls together in one access.
        flag_bus.set[MRSC_FL_SOFT] = rise[MRSC_IN_SOFT];
        // Chip reset clears the core, watchdog and soft flags; the
        // external flag is exempt and is instead set by the same pulse.
        flag_bus.clr = sw_clear |
            (chip_pulse ? MRSC_CHIP_CLEAR_MASK : 5'h00);
    end

    mrsc_flags u_flags (
        .clock (clock),
        .reset (reset),
        .fl    (flag_bus.owner)
    );

    // ==================================================================
    // Read views. Reserved bits read as zero.
    always_comb begin
        ctl_view                       = '0;
        ctl_view[MRSC_CTL_RELEASE_BIT] = state.periph_release;
        st_view                        = '0;
        st_view[MRSC_ST_SCHEME_MSB:MRSC_ST_SCHEME_LSB] = state.scheme;
        st_view[MRSC_ST_IDLE_BIT] = state.sync[MRSC_IN_IDLE];
        st_view[MRSC_ST_FLAG_MSB:MRSC_ST_FLAG_LSB] = flag_bus.flags;
    end

    // ==================================================================
    // Next-state logic for the whole block.
    always_comb begin
        next_state      = state;
        next_state.meta = raw_in;
        next_state.sync = state.meta;
        next_state.prev = state.sync;
        next_state.ack  = bus_sel;
        if (wr_ctl) begin
            // Only bit 0 is stored; the rest of the word is dropped.
            next_state.periph_release =
                bus_wdata[MRSC_CTL_RELEASE_BIT];
        end
        // Reserved scheme codes are refused so the clock tree never sees
        // an undefined selection; the old scheme stays active.
        if (wr_st && mrsc_scheme_ok(wr_scheme)) begin
            next_state.scheme = wr_scheme;
        end
        if (bus_sel && !bus_write) begin
            if (bus_addr == MRSC_IDX_CONTROL) begin
                next_state.rdata = ctl_view;
            end else begin
                next_state.rdata = st_view;
            end
        end else begin
            next_state.rdata = '0;
        end
    end

    // ==================================================================
    // State register. Every field takes a constant under reset.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state.periph_release <= MRSC_CTL_RELEASE_RST;
            state.scheme         <= MRSC_SCHEME_RST;
            state.meta           <= MRSC_IN_RST;
            state.sync           <= MRSC_IN_RST;
            state.prev           <= MRSC_IN_RST;
            state.rdata          <= '0;
            state.ack            <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ==================================================================
    // Outputs, all straight from flip-flops.
    assign host_periph_reset_n = state.periph_release;
    assign clock_scheme        = state.scheme;
    assign bus_rdata           = state.rdata;
    assign bus_ack             = state.ack;
endmodule

//--- pkg/mrsc_flag_if.sv
// Interface carrying set, clear and value vectors of the reset-cause flags.
`timescale 1ns/1ps
interface mrsc_flag_if;
    logic [4:0] set;   // Hardware event pulses.
    logic [4:0] clr;   // Clear requests.
    logic [4:0] flags; // Current flag values.

    modport owner (input set, input clr, output flags);
    modport user  (output set, output clr, input flags);
endinterface

//--- pkg/mrsc_pkg.sv
// Package with register map, field layout and codes of the reset status block.
package mrsc_pkg;

    // ==================================================================
    // Register indices on the register port.
    localparam logic [0:0] MRSC_IDX_CONTROL = 1'h0;
    localparam logic [0:0] MRSC_IDX_STATUS  = 1'h1;
    localparam int         MRSC_DATA_W      = 16;

    // ==================================================================
    // Control register layout.
    localparam int         MRSC_CTL_RELEASE_BIT = 0;
    localparam logic       MRSC_CTL_RELEASE_RST = 1'h0;

    // ==================================================================
    // Status register layout.
    localparam int MRSC_ST_SCHEME_LSB = 11;
    localparam int MRSC_ST_SCHEME_MSB = 13;
    localparam int MRSC_ST_IDLE_BIT   = 6;
    localparam int MRSC_ST_FLAG_LSB   = 1;
    localparam int MRSC_ST_FLAG_MSB   = 5;
    localparam int MRSC_FLAG_W        = 5;

    // Flag vector order, matching status bits 1 to 5.
    localparam int MRSC_FL_SOFT = 0;
    localparam int MRSC_FL_WD   = 1;
    localparam int MRSC_FL_CORE = 2;
    localparam int MRSC_FL_EXT  = 3;
    localparam int MRSC_FL_POR  = 4;

    // Flags that a chip reset input pulse clears.
    localparam logic [4:0] MRSC_CHIP_CLEAR_MASK = 5'h07;
    localparam logic [4:0] MRSC_FLAG_RST        = 5'h00;

    // ==================================================================
    // Clocking schemes.
    localparam logic [2:0] MRSC_SCHEME_FULL_SYNC = 3'h0;
    localparam logic [2:0] MRSC_SCHEME_SCALABLE  = 3'h2;
    localparam logic [2:0] MRSC_SCHEME_RST       = 3'h0;

    // ==================================================================
    // Synchronised inputs, all active high after input inversion.
    localparam int         MRSC_IN_W    = 6;
    localparam int         MRSC_IN_CHIP = 0;
    localparam int         MRSC_IN_IDLE = 1;
    localparam int         MRSC_IN_POR  = 2;
    localparam int         MRSC_IN_CORE = 3;
    localparam int         MRSC_IN_WD   = 4;
    localparam int         MRSC_IN_SOFT = 5;
    localparam logic [5:0] MRSC_IN_RST  = 6'h00;

    // Rising-edge detect, used on every event input.
    function automatic logic [5:0] mrsc_rise(input logic [5:0] cur,
                                             input logic [5:0] prev);
        return cur & ~prev;
    endfunction

    // True for the two scheme codes that hardware accepts.
    function automatic logic mrsc_scheme_ok(input logic [2:0] code);
        return (code == MRSC_SCHEME_FULL_SYNC) ||
               (code == MRSC_SCHEME_SCALABLE);
    endfunction

endpackage

//--- sim/mrsc_event_src.sv
// Model of the reset event sources and the DSP idle line.
`timescale 1ns/1ps
module mrsc_event_src
    import mrsc_pkg::*;
(
    input  wire logic clock,              // Clock.
    output logic      chip_reset_in_n,    // Chip reset pin.
    output logic      dsp_idle,           // DSP idle level.
    output logic      power_on_detect,    // Cold start.
    output logic      core_reset_detect,  // Core reset.
    output logic      watchdog_detect,    // Watchdog.
    output logic      soft_reset_request  // Soft reset.
);
    // Starts inactive, since a high level at release counts as an event.
    logic [MRSC_IN_W-1:0] lvl = MRSC_IN_RST;

    // Pin levels; the chip reset pin idles high.
    assign chip_reset_in_n    = ~lvl[MRSC_IN_CHIP];
    assign dsp_idle           = lvl[MRSC_IN_IDLE];
    assign power_on_detect    = lvl[MRSC_IN_POR];
    assign core_reset_detect  = lvl[MRSC_IN_CORE];
    assign watchdog_detect    = lvl[MRSC_IN_WD];
    assign soft_reset_request = lvl[MRSC_IN_SOFT];

    // Moves one source just after an edge, so it is sampled cleanly.
    task automatic drive(input int k, input logic v);
        @(posedge clock);
        #1;
        lvl[k] = v;
    endtask
endmodule

//--- sim/mrsc_properties.sv
// Port checker of the reset status block, bound to its top module.
`timescale 1ns/1ps
module mrsc_properties
    import mrsc_pkg::*;
(
    input wire logic        clock,               // Clock.
    input wire logic        reset,               // Reset.
    input wire logic        bus_sel,             // Strobe.
    input wire logic        bus_write,           // Write.
    input wire logic [0:0]  bus_addr,            // Index.
    input wire logic [15:0] bus_wdata,           // Wdata.
    input wire logic [15:0] bus_rdata,           // Rdata.
    input wire logic        bus_ack,             // Ack.
    input wire logic        chip_reset_in_n,     // Chip reset.
    input wire logic        dsp_idle,            // Idle.
    input wire logic        power_on_detect,     // Cold start.
    input wire logic        core_reset_detect,   // Core reset.
    input wire logic        watchdog_detect,     // Watchdog.
    input wire logic        soft_reset_request,  // Soft reset.
    input wire logic        host_periph_reset_n, // Periph reset.
    input wire logic [2:0]  clock_scheme         // Scheme.
);
    logic wr_ctl, wr_st, rd_ctl, rd_st, code_ok;

    // =================
    // Decoded accesses.
    assign wr_ctl  = bus_sel && bus_write && !bus_addr;
    assign wr_st   = bus_sel && bus_write && bus_addr;
    assign rd_ctl  = bus_sel && !bus_write && !bus_addr;
    assign rd_st   = bus_sel && !bus_write && bus_addr;
    assign code_ok = bus_wdata[13:11] == 3'h0 || bus_wdata[13:11] == 3'h2;

    // =================
    // Properties; reset suspends all of them.
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    a_ack_pulse: assert property (
        bus_ack == $past(bus_sel))
        else $error("ack not one cycle after strobe");
    a_release_ctl: assert property (
        wr_ctl |=> host_periph_reset_n == $past(bus_wdata[0]))
        else $error("periph reset differs from written bit");
    a_periph_hold: assert property (
        !wr_ctl |=> $stable(host_periph_reset_n))
        else $error("periph reset moved without write");
    a_ctl_read: assert property (
        $past(rd_ctl) |-> bus_rdata == {15'h0, host_periph_reset_n})
        else $error("control read wrong");
    a_resv_zero: assert property (
        $past(rd_st) |-> (bus_rdata & 16'hc781) == 16'h0)
        else $error("reserved status bits not zero");
    a_scheme_read: assert property (
        $past(rd_st) |-> bus_rdata[13:11] == clock_scheme)
        else $error("scheme readback wrong");
    a_scheme_wr: assert property (
        wr_st && code_ok |=> clock_scheme == $past(bus_wdata[13:11]))
        else $error("scheme write lost");
    a_scheme_resv: assert property (
        wr_st && !code_ok |=> $stable(clock_scheme))
        else $error("reserved scheme accepted");
    a_reset_vals: assert property (
        $fell(reset) |-> !host_periph_reset_n && clock_scheme == 3'h0)
        else $error("outputs not at reset values");

    c_release: cover property (wr_ctl && bus_wdata[0]);
    c_bad_code: cover property (wr_st && !code_ok);
    c_flag_read: cover property ($past(rd_st) && bus_rdata[5:1] != 5'h0);
endmodule

bind mrsc_top mrsc_properties mrsc_properties_i (.clock(clock), .reset(reset),
    .bus_sel(bus_sel), .bus_write(bus_write), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .chip_reset_in_n(chip_reset_in_n), .dsp_idle(dsp_idle),
    .power_on_detect(power_on_detect), .core_reset_detect(core_reset_detect),
    .watchdog_detect(watchdog_detect),
    .soft_reset_request(soft_reset_request),
    .host_periph_reset_n(host_periph_reset_n), .clock_scheme(clock_scheme));

//--- sim/tb_top.sv
// Self-checking bench of the reset status block.
`timescale 1ns/1ps
module tb_top;
    import mrsc_pkg::*;
    logic        clock, reset, bus_sel, bus_write, bus_ack, rel, idle;
    logic        chip_reset_in_n, dsp_idle, power_on_detect, core_reset_detect;
    logic        watchdog_detect, soft_reset_request, host_periph_reset_n;
    logic [0:0]  bus_addr;
    logic [15:0] bus_wdata, bus_rdata;
    logic [2:0]  clock_scheme, scheme;
    logic [4:0]  flags;
    logic [7:0]  lfsr;
    logic [16:0] expq[$];
    int          miscompares, checks_done, i;

    mrsc_top mrsc_top_i (
        .clock               (clock),
        .reset               (reset),
        .bus_sel             (bus_sel),
        .bus_write           (bus_write),
        .bus_addr            (bus_addr),
        .bus_wdata           (bus_wdata),
        .bus_rdata           (bus_rdata),
        .bus_ack             (bus_ack),
        .chip_reset_in_n     (chip_reset_in_n),
        .dsp_idle            (dsp_idle),
        .power_on_detect     (power_on_detect),
        .core_reset_detect   (core_reset_detect),
        .watchdog_detect     (watchdog_detect),
        .soft_reset_request  (soft_reset_request),
        .host_periph_reset_n (host_periph_reset_n),
        .clock_scheme        (clock_scheme)
    );
    mrsc_event_src mrsc_event_src_i (
        .clock               (clock),
        .chip_reset_in_n     (chip_reset_in_n),
        .dsp_idle            (dsp_idle),
        .power_on_detect     (power_on_detect),
        .core_reset_detect   (core_reset_detect),
        .watchdog_detect     (watchdog_detect),
        .soft_reset_request  (soft_reset_request)
    );

    // =================
    // Helpers.
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic cmp(input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask
    // One access; reads note their expected word for the monitor.
    task automatic acc(input logic w, input logic [0:0] a,
                       input logic [15:0] d);
        @(posedge clock);
        #1;
        bus_sel = 1'b1;
        bus_write = w;
        bus_addr = a;
        bus_wdata = d;
        expq.push_back({~w, a ? {2'h0, scheme, 4'h0, idle, flags, 1'b0}
                                : {15'h0, rel}});
        @(posedge clock);
        #1;
        bus_sel = 1'b0;
    endtask
    task automatic wr_st(input logic [15:0] d);
        acc(1'b1, MRSC_IDX_STATUS, d);
        if (d[13:11] == 3'h0 || d[13:11] == 3'h2) begin
            scheme = d[13:11];
        end
        flags &= d[5:1];
        cmp({13'h0, scheme}, {13'h0, clock_scheme});
    endtask
    // Pulses one event source and notes its effect on the flags.
    task automatic fire(input int k);
        mrsc_event_src_i.drive(k, 1'b1);
        mrsc_event_src_i.drive(k, 1'b0);
        repeat (4) @(posedge clock);
        case (k)
            MRSC_IN_CHIP: flags = {flags[4], 4'h8};
            MRSC_IN_POR:  flags[MRSC_FL_POR] = 1'b1;
            MRSC_IN_CORE: flags[MRSC_FL_CORE] = 1'b1;
            MRSC_IN_WD:   flags[MRSC_FL_WD] = 1'b1;
            default:      flags[MRSC_FL_SOFT] = 1'b1;
        endcase
    endtask
    task automatic give_verdict;
        // An access whose answer never came leaves its note behind.
        if (expq.size() != 0) begin
            miscompares++;
            $display("[ERR] %0t exp %h got %h", $time, 0, expq.size());
        end
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // =================
    // Clock, monitor and watchdog; a run needs under 400 cycles.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(negedge clock) begin
        if (bus_ack === 1'b1 && expq.size() > 0) begin
            if (expq[0][16]) cmp(expq[0][15:0], bus_rdata);
            void'(expq.pop_front());
        end else if (bus_ack !== 1'b0) begin
            // An answer with no access behind it is a fault too.
            cmp(16'h0, {15'h0, bus_ack});
        end
    end
    initial begin
        #500000;
        miscompares++;
        give_verdict();
    end

    // =================
    // Main sequence.
    initial begin
        reset = 1'b1;
        bus_sel = 1'b0;
        bus_write = 1'b0;
        bus_addr = 1'b0;
        bus_wdata = 16'h0;
        rel = 1'b0;
        scheme = 3'h0;
        flags = 5'h0;
        idle = 1'b0;
        lfsr = 8'h3a;
        repeat (10) @(posedge clock);
        #1 reset = 1'b0;
        repeat (4) @(posedge clock);
        acc(1'b0, MRSC_IDX_CONTROL, 16'h0);
        acc(1'b0, MRSC_IDX_STATUS, 16'h0);
        for (i = 0; i < 6; i++) begin
            lfsr = nxt(lfsr);
            acc(1'b1, MRSC_IDX_CONTROL, {lfsr, lfsr});
            rel = lfsr[0];
            cmp({15'h0, host_periph_reset_n}, {15'h0, rel});
            acc(1'b0, MRSC_IDX_CONTROL, 16'h0);
        end
        // Every scheme code, with reserved and flag bits all written 1.
        for (i = 0; i < 8; i++) begin
            wr_st({2'h3, i[2:0], 11'h7ff});
            acc(1'b0, MRSC_IDX_STATUS, 16'h0);
        end
        for (i = MRSC_IN_POR; i <= MRSC_IN_SOFT; i++) fire(i);
        acc(1'b0, MRSC_IDX_STATUS, 16'h0);
        wr_st({2'h0, scheme, 11'h7df});
        acc(1'b0, MRSC_IDX_STATUS, 16'h0);
        fire(MRSC_IN_CHIP);
        acc(1'b0, MRSC_IDX_STATUS, 16'h0);
        wr_st({2'h0, scheme, 11'h0});
        acc(1'b0, MRSC_IDX_STATUS, 16'h0);
        mrsc_event_src_i.drive(MRSC_IN_IDLE, 1'b1);
        repeat (4) @(posedge clock);
        idle = 1'b1;
        acc(1'b0, MRSC_IDX_STATUS, 16'h0);
        mrsc_event_src_i.drive(MRSC_IN_IDLE, 1'b0);
        repeat (4) @(posedge clock);
        idle = 1'b0;
        acc(1'b0, MRSC_IDX_STATUS, 16'h0);
        repeat (2) @(posedge clock);
        give_verdict();
    end
endmodule
